/* include/crs_pkg.sv */
package crs_pkg;
	// Opcode group fields
	localparam logic [3:0] CRS_COPY_HI = 4'h0;
	localparam logic [3:0] CRS_COPY_LO = 4'h2;
	localparam logic [3:0] CRS_PUSH_HI = 4'h4;
	localparam logic [3:0] CRS_PUSH_LO = 4'h3;
	// Source select, opcode bits 6..4
	localparam logic [2:0] CRS_FLD_SW = 3'h0;
	localparam logic [2:0] CRS_FLD_GB = 3'h1;
	localparam logic [2:0] CRS_FLD_VB = 3'h2;
	localparam logic [2:0] CRS_FLD_SS = 3'h3;
	localparam logic [2:0] CRS_FLD_SPC = 3'h4;
	localparam logic [2:0] CRS_FLD_MOD = 3'h5;
	localparam logic [2:0] CRS_FLD_RS = 3'h6;
	localparam logic [2:0] CRS_FLD_RE = 3'h7;
	// Status word bits
	localparam int CRS_SW_PRIV = 30;
	localparam int CRS_SW_BANK = 29;
	// Steps
	localparam logic [31:0] CRS_PUSH_STEP = 32'h0000_0004;
	localparam logic [31:0] CRS_PC_STEP = 32'h0000_0002;
	localparam logic [31:0] CRS_PC_RST = 32'h0000_0000;
	// APB byte offsets
	localparam logic [7:0] CRS_A_CTRL = 8'h00;
	localparam logic [7:0] CRS_A_STAT = 8'h04;
	localparam logic [7:0] CRS_A_MASK = 8'h08;
	localparam logic [7:0] CRS_A_PC = 8'h0C;
	localparam logic [7:0] CRS_A_GSEL = 8'h10;
	localparam logic [7:0] CRS_A_GDAT = 8'h14;
	// Event bit positions, reset values
	localparam int CRS_EV_DONE = 0;
	localparam int CRS_EV_ILL = 1;
	localparam int CRS_EV_UNDEC = 2;
	localparam logic [2:0] CRS_EV_RST = 3'h0;
	localparam logic CRS_CTRL_RST = 1'b0;
	localparam logic [4:0] CRS_NSLOT = 5'h18;
	// Source kinds
	typedef enum logic [3:0] {
		CRS_SRC_SW, CRS_SRC_GB, CRS_SRC_VB,
		CRS_SRC_SS, CRS_SRC_SPC, CRS_SRC_MOD,
		CRS_SRC_RS, CRS_SRC_RE, CRS_SRC_BANK
	} crs_src_t;
	// Control register values from the core
	typedef struct packed {
		logic [31:0] statusWord;
		logic [31:0] globalBase;
		logic [31:0] vectorBase;
		logic [31:0] savedStatus;
		logic [31:0] savedProgramCounter;
		logic [31:0] moduloRegister;
		logic [31:0] repeatEnd;
		logic [31:0] repeatStart;
	} crs_ctrl_t;
	// Decode result
	typedef struct packed {
		logic hit;
		logic push;
		logic userOk;
		crs_src_t src;
		logic [2:0] bankSel;
	} crs_dec_t;
	// APB request
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} crs_apb_t;
	// Memory write request
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
	} crs_mem_t;
endpackage : crs_pkg

/* core/crs_store_exec.sv */
// Notes on behaviour
// - Copy status, global, vector base to target
// - Copy saved status/PC; decode PC push
// - DSP variant only: modulo, repeat copies
// - Copy inactive bank regs, bits 6..4
// - Push: decrement target by 4, write
// - Push global, vector base, saved status
// - Basic pushes: one cycle, DSP two
// - DSP variant only: modulo, repeat pushes
// - Push inactive bank regs, two cycles
// - Privileged except global base; else trap
// - Global base forms allowed in user mode
// - Bank select bit picks banked source
// - Bit one: active bank 1, source 0
// - Bit zero: active bank 0, source 1
`timescale 1ns/1ps
`default_nettype none
module crs_store_exec (
	input wire logic clock, // Core clock
	input wire logic rst, // Async reset, high
	input wire crs_pkg::crs_apb_t apbReq, // APB request
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	output logic irq, // Level interrupt
	input wire logic instrValid, // Opcode offered
	input wire logic [15:0] instrOpcode, // Opcode
	output logic instrReady, // Opcode taken
	input wire crs_pkg::crs_ctrl_t ctrlRegs, // Control values
	input wire logic tFlagIn, // Condition flag in
	output logic tFlagOut, // Condition flag out
	output logic memValid, // Write request
	output crs_pkg::crs_mem_t memReq, // Write addr/data
	input wire logic memReady, // Write accepted
	output logic done, // Completion pulse
	output logic illegalExc, // Privilege trap pulse
	output logic undecoded, // Not this group
	output logic [31:0] pcValue // Program counter
);
	import crs_pkg::*;

	////////////////////////////////////////////////
	// Functions

	// Group decode; DSP-only codes miss otherwise
	function automatic crs_dec_t decodeOp(
		input logic [15:0] op,
		input logic dsp
	);
		crs_dec_t d;
		d.hit = 1'b0;
		d.push = 1'b0;
		d.userOk = 1'b0;
		d.src = CRS_SRC_SW;
		d.bankSel = op[6:4];
		if ((op[15:12] == CRS_COPY_HI &&
			op[3:0] == CRS_COPY_LO) ||
			(op[15:12] == CRS_PUSH_HI &&
			op[3:0] == CRS_PUSH_LO)) begin
			d.hit = 1'b1;
			d.push = (op[15:12] == CRS_PUSH_HI);
			if (op[7]) begin
				d.src = CRS_SRC_BANK;
			end else begin
				case (op[6:4])
					CRS_FLD_SW: d.src = CRS_SRC_SW;
					CRS_FLD_GB: begin
						d.src = CRS_SRC_GB;
						d.userOk = 1'b1;
					end
					CRS_FLD_VB: d.src = CRS_SRC_VB;
					CRS_FLD_SS: d.src = CRS_SRC_SS;
					CRS_FLD_SPC: d.src = CRS_SRC_SPC;
					CRS_FLD_MOD: d.src = CRS_SRC_MOD;
					CRS_FLD_RS: d.src = CRS_SRC_RS;
					default: d.src = CRS_SRC_RE;
				endcase
				// Modulo and repeat codes exist only with DSP
				if (op[6:4] >= CRS_FLD_MOD)
					d.hit = dsp;
			end
		end
		return d;
	endfunction : decodeOp

	// Physical slot of target register:
	// 0..7 bank 0, 8..15 bank 1, 16..23 shared
	function automatic logic [4:0] gprSlot(
		input logic [3:0] n,
		input logic rb
	);
		if (n[3])
			return {2'b10, n[2:0]};
		return rb ? {2'b01, n[2:0]} :
			{2'b00, n[2:0]};
	endfunction : gprSlot

	////////////////////////////////////////////////
	// Declarations

	typedef enum logic [1:0] {
		CRS_IDLE, CRS_STALL, CRS_MEMWR
	} crs_state_t;

	crs_state_t state_r; // Sequencer state
	logic [31:0] gpr_r [24]; // Register file
	logic [31:0] pc_r; // Program counter
	logic tFlag_r; // Held condition flag
	logic dspMode_r; // DSP variant enable
	logic [2:0] evStat_r; // Sticky events
	logic [2:0] evMask_r; // Event mask
	logic [4:0] gprSel_r; // Debug slot select
	logic [31:0] prdata_r; // Read data
	crs_mem_t memReq_r; // Pending write
	logic done_r; // Done pulse
	logic ill_r; // Trap pulse
	logic undec_r; // Miss pulse
	crs_dec_t dec; // Current decode
	logic bankBit; // Bank select bit
	logic userMode; // Not privileged
	logic take; // Opcode accepted
	logic trap; // Privilege violation
	logic execOk; // Will execute
	logic finish; // Instruction retires
	logic [4:0] dstSlot; // Target slot
	logic [4:0] bankSlot; // Banked source slot
	logic [31:0] srcVal; // Selected value
	logic [31:0] decAddr; // Target minus four
	logic apbSetup; // Setup phase
	logic apbWr; // Write access
	logic apbRd; // Read access
	logic mapped; // Address decoded

	////////////////////////////////////////////////
	// Decode and privilege
	// Decode and privilege terms
	always_comb begin
		dec = decodeOp(instrOpcode, dspMode_r);
		bankBit = ctrlRegs.statusWord[CRS_SW_BANK];
		userMode = ~ctrlRegs.statusWord[CRS_SW_PRIV];
		take = instrValid && (state_r == CRS_IDLE);
		trap = dec.hit && userMode && !dec.userOk;
		execOk = dec.hit && !trap;
		dstSlot = gprSlot(instrOpcode[11:8], bankBit);
		// Inactive bank is the source
		bankSlot = bankBit ? {2'b00, dec.bankSel} :
			{2'b01, dec.bankSel};
		decAddr = gpr_r[dstSlot] - CRS_PUSH_STEP;
	end

	// Source value select
	always_comb begin
		case (dec.src)
			CRS_SRC_SW: srcVal = ctrlRegs.statusWord;
			CRS_SRC_GB: srcVal = ctrlRegs.globalBase;
			CRS_SRC_VB: srcVal = ctrlRegs.vectorBase;
			CRS_SRC_SS: srcVal = ctrlRegs.savedStatus;
			CRS_SRC_SPC: srcVal = ctrlRegs.savedProgramCounter;
			CRS_SRC_MOD: srcVal = ctrlRegs.moduloRegister;
			CRS_SRC_RS: srcVal = ctrlRegs.repeatStart;
			CRS_SRC_RE: srcVal = ctrlRegs.repeatEnd;
			default: srcVal = gpr_r[bankSlot];
		endcase
	end

	// Retire on copy, or when the write is taken
	assign finish = (take && execOk && !dec.push) ||
		(state_r == CRS_MEMWR && memReady);
	assign instrReady = (state_r == CRS_IDLE);
	assign memValid = (state_r == CRS_MEMWR);

	////////////////////////////////////////////////
	// Push sequencer
	// Base variant goes straight to memory except for banked
	// pushes; the DSP variant spends one extra cycle first
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_r <= CRS_IDLE;
		end else begin
			case (state_r)
				CRS_IDLE: begin
					if (take && execOk && dec.push)
						state_r <= (dspMode_r || dec.src == CRS_SRC_BANK) ?
							CRS_STALL : CRS_MEMWR;
				end
				CRS_STALL: state_r <= CRS_MEMWR;
				default: begin
					if (memReady)
						state_r <= CRS_IDLE;
				end
			endcase
		end
	end

	// Latch write address and data at accept
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			memReq_r <= '0;
		end else if (take && execOk && dec.push) begin
			memReq_r.addr <= decAddr;
			memReq_r.data <= srcVal;
		end
	end
	assign memReq = memReq_r;

	////////////////////////////////////////////////
	// Register file
	// Instruction write wins over a debug write
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 24; i++)
				gpr_r[i] <= '0;
		end else begin
			if (apbWr && apbReq.paddr == CRS_A_GDAT &&
				gprSel_r < CRS_NSLOT)
				gpr_r[gprSel_r] <= apbReq.pwdata;
			if (take && execOk)
				gpr_r[dstSlot] <= dec.push ?
					decAddr : srcVal;
		end
	end

	////////////////////////////////////////////////
	// Program counter, flag, pulses
	// Advance only on retire; traps leave PC
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pc_r <= CRS_PC_RST;
		end else if (finish) begin
			pc_r <= pc_r + CRS_PC_STEP;
		end else if (apbWr && apbReq.paddr == CRS_A_PC) begin
			pc_r <= apbReq.pwdata;
		end
	end

	// Flag passes untouched by this group
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			tFlag_r <= 1'b0;
		else
			tFlag_r <= tFlagIn;
	end

	// One-cycle outcome pulses
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			done_r <= 1'b0;
			ill_r <= 1'b0;
			undec_r <= 1'b0;
		end else begin
			done_r <= finish;
			ill_r <= take && trap;
			undec_r <= take && !dec.hit;
		end
	end

	assign done = done_r;
	assign illegalExc = ill_r;
	assign undecoded = undec_r;
	assign tFlagOut = tFlag_r;
	assign pcValue = pc_r;

	////////////////////////////////////////////////
	// APB slave
	// Zero wait states; bad offsets flag error
	always_comb begin
		// Decode first, so the write term sees it
		if (apbReq.paddr <= CRS_A_GDAT && apbReq.paddr[1:0] == 2'b00)
			mapped = 1'b1;
		else
			mapped = 1'b0;
		apbSetup = apbReq.psel && !apbReq.penable;
		apbWr = apbReq.psel && apbReq.penable &&
			apbReq.pwrite && mapped;
		apbRd = apbReq.psel && apbReq.penable &&
			!apbReq.pwrite;
	end
	assign pready = 1'b1;
	assign pslverr = apbReq.psel && apbReq.penable &&
		!mapped;

	// Read data captured in setup phase
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			prdata_r <= '0;
		end else if (apbSetup) begin
			if (apbReq.paddr == CRS_A_CTRL)
				prdata_r <= {31'h0, dspMode_r};
			else if (apbReq.paddr == CRS_A_STAT)
				prdata_r <= {29'h0, evStat_r};
			else if (apbReq.paddr == CRS_A_MASK)
				prdata_r <= {29'h0, evMask_r};
			else if (apbReq.paddr == CRS_A_PC)
				prdata_r <= pc_r;
			else if (apbReq.paddr == CRS_A_GSEL)
				prdata_r <= {27'h0, gprSel_r};
			else if (apbReq.paddr == CRS_A_GDAT &&
				gprSel_r < CRS_NSLOT)
				prdata_r <= gpr_r[gprSel_r];
			else
				prdata_r <= '0;
		end
	end
	assign prdata = prdata_r;

	// Writable control fields
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			dspMode_r <= CRS_CTRL_RST;
			evMask_r <= CRS_EV_RST;
			gprSel_r <= '0;
		end else if (apbWr) begin
			if (apbReq.paddr == CRS_A_CTRL)
				dspMode_r <= apbReq.pwdata[0];
			else if (apbReq.paddr == CRS_A_MASK)
				evMask_r <= apbReq.pwdata[2:0];
			else if (apbReq.paddr == CRS_A_GSEL)
				gprSel_r <= apbReq.pwdata[4:0];
		end
	end

	////////////////////////////////////////////////
	// Interrupt status
	// Read clears only bits it returned; later events stay
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			evStat_r <= CRS_EV_RST;
		end else begin
			if (apbRd && apbReq.paddr == CRS_A_STAT)
				evStat_r <= (evStat_r & ~prdata_r[2:0]) |
					{undec_r, ill_r, done_r};
			else
				evStat_r <= evStat_r |
					{undec_r, ill_r, done_r};
		end
	end
	assign irq = |(evStat_r & evMask_r);
endmodule : crs_store_exec
`default_nettype wire

/* tb/crs_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module crs_chk (
	input wire logic clock, // Core clock
	input wire logic rst, // Reset
	input wire logic instrValid, // Opcode offered
	input wire logic [15:0] instrOpcode, // Opcode
	input wire logic instrReady, // Idle
	input wire crs_pkg::crs_ctrl_t ctrlRegs, // Control values
	input wire logic tFlagIn, // Flag in
	input wire logic tFlagOut, // Flag out
	input wire logic memValid, // Write request
	input wire crs_pkg::crs_mem_t memReq, // Write word
	input wire logic memReady, // Write accepted
	input wire logic done, // Retire pulse
	input wire logic illegalExc, // Trap pulse
	input wire logic [31:0] pcValue // Program counter
);
	import crs_pkg::*;
	logic take; // Accept edge
	logic priv; // Privileged mode
	logic [11:0] op; // High nibble and low byte
	assign take = instrValid && instrReady;
	assign priv = ctrlRegs.statusWord[CRS_SW_PRIV];
	assign op = {instrOpcode[15:12], instrOpcode[7:0]};
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////
	a_user_trap: assert property (take && !priv && op == 12'h002 |=> illegalExc)
		else $error("user status copy not trapped");
	a_gb_user: assert property (take && !priv && op == 12'h012 |=> done && !illegalExc)
		else $error("user global base copy refused");
	a_bank_push: assert property (take && priv && op[11:8] == 4'h4 && op[7] && op[3:0] == 4'h3
		|=> !memValid ##1 memValid)
		else $error("banked push not two cycles");
	a_trap_quiet: assert property (illegalExc |-> !done && !memValid && $stable(pcValue))
		else $error("trap had side effects");
	a_pc_step: assert property (done |-> pcValue == $past(pcValue) + CRS_PC_STEP)
		else $error("pc not advanced by one opcode");
	a_flag_pass: assert property (!$past(rst) |-> tFlagOut == $past(tFlagIn))
		else $error("flag altered");
	a_req_hold: assert property (memValid && !memReady |=> memValid && $stable(memReq))
		else $error("write request dropped or changed");
	a_write_done: assert property (memValid && memReady |=> done && !memValid)
		else $error("push did not retire after write");
	a_busy_hold: assert property (memValid |-> !instrReady)
		else $error("opcode taken during push");
endmodule : crs_chk
bind crs_store_exec crs_chk u_crs_chk (.clock, .rst, .instrValid, .instrOpcode, .instrReady,
	.ctrlRegs, .tFlagIn, .tFlagOut, .memValid, .memReq, .memReady, .done, .illegalExc,
	.pcValue);
`default_nettype wire

/* tb/crs_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module crs_mem_model (
	input wire logic clock, // Core clock
	input wire logic rst, // Reset
	input wire logic memValid, // Write request
	input wire crs_pkg::crs_mem_t memReq, // Address and data
	input wire logic [1:0] stall, // Cycles to hold off
	output logic memReady, // Write accepted
	output crs_pkg::crs_mem_t wrLast, // Last word taken
	output logic [31:0] wrCount // Words taken
);
	import crs_pkg::*;
	logic [1:0] waitCnt; // Cycles held off so far
	// Slow answers stretch the request, so the core must hold it
	assign memReady = memValid && waitCnt == stall;
	// Log every whole 32-bit word taken
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			waitCnt <= 2'd0;
			wrLast <= '0;
			wrCount <= 32'd0;
		end else if (memReady) begin
			waitCnt <= 2'd0;
			wrLast <= memReq;
			wrCount <= wrCount + 32'd1;
		end else if (memValid) begin
			waitCnt <= waitCnt + 2'd1;
		end
	end
endmodule : crs_mem_model
`default_nettype wire

/* tb/crs_store_exec_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module crs_store_exec_tb;
	import crs_pkg::*;
	logic clock, rst, pready, pslverr, irq, instrValid, instrReady; // Controls
	logic tFlagIn, tFlagOut, memValid, memReady, done, illegalExc, undecoded; // Flags
	logic [31:0] prdata, pcValue, wrCount; // Words
	logic [15:0] instrOpcode; // Opcode
	logic [1:0] stall; // Memory hold-off
	crs_apb_t apbReq; // APB request
	crs_ctrl_t ctrlRegs; // Control values
	crs_mem_t memReq, wrLast; // Write words
	logic [31:0] gm [24]; // Register file model
	logic [31:0] pcM, wrN; // Pc and write count model
	logic [31:0] seed = 32'h1041_481a; // Random state
	logic [2:0] mask; // Interrupt mask model
	logic dsp; // Variant model
	int fails, samplesChecked; // Tallies
	crs_store_exec u_crs_store_exec (.clock, .rst, .apbReq, .prdata, .pready, .pslverr,
		.irq, .instrValid, .instrOpcode, .instrReady, .ctrlRegs, .tFlagIn, .tFlagOut,
		.memValid, .memReq, .memReady, .done, .illegalExc, .undecoded, .pcValue);
	crs_mem_model u_crs_mem_model (.clock, .rst, .memValid, .memReq, .stall, .memReady,
		.wrLast, .wrCount);
	////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic complete_run();
		if (fails == 0 && samplesChecked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samplesChecked++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	// A spent bound ends the run
	task automatic guard(input int k);
		if (k >= 20) begin
			fails++;
			complete_run();
		end
	endtask : guard
	// One APB transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int k;
		@(posedge clock);
		apbReq <= '{1'b1, 1'b0, w, a, d};
		@(posedge clock);
		apbReq.penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (pready !== 1'b1 && k < 20);
		guard(k);
		q = prdata;
		e = pslverr;
		apbReq <= '0;
	endtask : apb
	// One opcode against the model
	task automatic exec(input logic [15:0] op, input logic [31:0] sw);
		int t, s, k, x;
		logic pu, e;
		logic [31:0] v, ev, q;
		crs_ctrl_t cr;
		cr = {sw, rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
		t = (op[11] || sw[CRS_SW_BANK]) ? 8 + op[11:8] : op[11:8];
		s = (op[6:4] > 5) ? op[6:4] ^ 1 : op[6:4];
		v = op[7] ? gm[sw[CRS_SW_BANK] ? op[6:4] : 8 + op[6:4]] : cr[255 - 32 * s -: 32];
		pu = op[15:12] == CRS_PUSH_HI && op[3:0] == CRS_PUSH_LO;
		ev = 32'h0000_0004;
		if ((pu || (op[15:12] == CRS_COPY_HI && op[3:0] == CRS_COPY_LO)) && (op[7] || s < 5 || dsp))
			ev = 32'h0000_0001;
		if (ev[0] && !sw[CRS_SW_PRIV] && (op[7] || op[6:4] != CRS_FLD_GB))
			ev = 32'h0000_0002;
		if (ev[0]) begin
			pcM = pcM + CRS_PC_STEP;
			if (pu) begin
				gm[t] = gm[t] - CRS_PUSH_STEP;
				wrN++;
			end else begin
				gm[t] = v;
			end
		end
		@(posedge clock);
		ctrlRegs <= cr;
		tFlagIn <= cr.globalBase[0];
		stall <= cr.vectorBase[1:0];
		instrValid <= 1'b1;
		instrOpcode <= op;
		@(posedge clock);
		instrValid <= 1'b0;
		k = 0;
		// Copy, trap and miss pulses stand right after the accept edge; push pulses come later
		#1;
		while ({done, illegalExc, undecoded} === 3'b000 && k < 20) begin
			@(posedge clock);
			#1;
			k++;
		end
		guard(k);
		x = (ev[0] && pu) ? 1 + cr.vectorBase[1:0] + (dsp || op[7]) : 0;
		chk("cycles", x, k);
		chk("flag", {31'd0, cr.globalBase[0]}, {31'd0, tFlagOut});
		chk("event", ev, {29'd0, undecoded, illegalExc, done});
		chk("pc", pcM, pcValue);
		chk("writes", wrN, wrCount);
		if (ev[0] && pu) begin
			chk("addr", gm[t], wrLast.addr);
			chk("data", v, wrLast.data);
		end
		apb(1'b1, CRS_A_GSEL, t, q, e);
		apb(1'b0, CRS_A_GDAT, 32'd0, q, e);
		chk("gpr", gm[t], q);
		chk("irq", {31'd0, |(ev[2:0] & mask)}, {31'd0, irq});
		apb(1'b0, CRS_A_STAT, 32'd0, q, e);
		chk("status", ev, q);
	endtask : exec
	////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	initial begin
		logic [31:0] q, r;
		logic e;
		{rst, instrValid, tFlagIn, dsp} = 4'b1000;
		{apbReq, instrOpcode, ctrlRegs, stall, pcM, wrN} = '0;
		{fails, samplesChecked} = '0;
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		apb(1'b0, CRS_A_STAT, 32'd0, q, e);
		chk("status rst", {29'd0, CRS_EV_RST}, q);
		apb(1'b0, 8'h18, 32'd0, q, e);
		chk("slverr", 32'd1, {31'd0, e});
		for (int i = 0; i < 24; i++) begin
			gm[i] = rnd();
			apb(1'b1, CRS_A_GSEL, i, q, e);
			apb(1'b1, CRS_A_GDAT, gm[i], q, e);
		end
		mask = 3'h3;
		apb(1'b1, CRS_A_MASK, {29'd0, mask}, q, e);
		exec(16'h0302, 32'h0000_0000);
		exec(16'h0512, 32'h0000_0000);
		exec(16'h4613, 32'h0000_0000);
		exec(16'h4793, 32'h6000_0000);
		for (int i = 0; i < 160; i++) begin
			if (i == 80) begin
				{dsp, mask} = 4'hf;
				apb(1'b1, CRS_A_CTRL, 32'd1, q, e);
				apb(1'b1, CRS_A_MASK, {29'd0, mask}, q, e);
			end
			r = rnd();
			exec(r[3:1] == 0 ? r[15:0] : {r[0] ? CRS_PUSH_HI : CRS_COPY_HI, r[11:4],
				r[0] ? CRS_PUSH_LO : CRS_COPY_LO}, rnd());
		end
		complete_run();
	end
endmodule : crs_store_exec_tb
`default_nettype wire
